// file: pte_engine.sv
// Pattern and handshake data mover between connector ports and host memory.
// Assumes pins arrive asynchronous; host side uses valid/ready words.
`timescale 1ns/1ps
module pte_engine (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Software control
  input  wire pte_pkg::pte_cfg_t            cfg,
  input  wire logic                         arm,
  input  wire logic                         swStop,
  input  wire logic [pte_pkg::PRELOAD_W-1:0] preloadAmount,
  input  wire logic                         readCountLow,
  input  wire logic                         countSelOut,
  input  wire logic                         countSelGrp2,
  output logic      [31:0]                  countLow,
  output logic      [31:0]                  countHigh,
  output logic                              busy,
  output logic                              progressEvent,
  output logic                              sampleEvent,
  // Host memory side, inbound words
  output pte_pkg::pte_word_t                toHost,
  output logic                              toHostValid,
  output logic                              toHostBurst,
  input  wire logic                         toHostReady,
  // Host memory side, outbound words
  input  wire pte_pkg::pte_word_t           fromHost,
  input  wire logic                         fromHostValid,
  output logic                              fromHostReady,
  // Connector pins
  input  wire logic                         reqPin,
  input  wire logic                         beginTriggerPin,
  input  wire logic                         haltTriggerPin,
  input  wire logic [31:0]                  portIn,
  output logic      [31:0]                  portOut,
  output logic      [31:0]                  portOe_n,
  output logic                              ackOut
);
  localparam int AW = pte_pkg::FIFO_AW;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]  syncA;
  logic [2:0]  syncB;
  logic        reqPrev;
  logic [31:0] portSyncA;
  logic [31:0] portSyncB;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA     <= 3'h0;
      syncB     <= 3'h0;
      reqPrev   <= 1'b0;
      portSyncA <= pte_pkg::WORD_RESET;
      portSyncB <= pte_pkg::WORD_RESET;
    end else begin
      syncA     <= {haltTriggerPin, beginTriggerPin, reqPin};
      syncB     <= syncA;
      reqPrev   <= syncB[0];
      portSyncA <= portIn;
      portSyncB <= portSyncA;
    end
  end
  logic reqEdge;
  logic beginSeen;
  logic haltSeen;
  assign reqEdge   = cfg.reqFalling ? (reqPrev & ~syncB[0])
                                    : (~reqPrev & syncB[0]);
  assign beginSeen = syncB[1];
  assign haltSeen  = syncB[2];
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pte_pkg::pte_state_t state;
  logic                started;
  logic [pte_pkg::PRELOAD_W-1:0] preloaded;
  logic                finalPending;
  logic                fifoEmpty;
  logic                fifoFull;
  logic                sampleTake;
  logic                rawLast;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= pte_pkg::PTE_IDLE;
      started      <= 1'b0;
      preloaded    <= '0;
      finalPending <= 1'b0;
    end else begin
      case (state)
        pte_pkg::PTE_IDLE: begin
          if (arm) begin
            started      <= ~cfg.useBegin | cfg.handshake;
            preloaded    <= '0;
            finalPending <= 1'b0;
            if (cfg.outputDir && !cfg.preloadOff && preloadAmount != '0) begin
              state <= pte_pkg::PTE_PRELOAD;
            end else begin
              state <= pte_pkg::PTE_RUN;
            end
          end
        end
        pte_pkg::PTE_PRELOAD: begin
          if (fromHostValid && fromHostReady) begin
            preloaded <= preloaded + 1'b1;
          end
          if (swStop) begin
            state <= pte_pkg::PTE_IDLE;
          end else if (preloaded == preloadAmount || fifoFull) begin
            state <= pte_pkg::PTE_RUN;
          end
        end
        pte_pkg::PTE_RUN: begin
          if (!started && beginSeen) begin
            started <= 1'b1;
          end
          if (swStop || (started && cfg.useHalt && haltSeen)) begin
            state <= pte_pkg::PTE_FLUSH;
          end else if (cfg.finite && sampleTake && rawLast) begin
            finalPending <= ~cfg.outputDir & ~cfg.handshake;
            if (cfg.outputDir || cfg.handshake) begin
              state <= pte_pkg::PTE_FLUSH;
            end
          end else if (finalPending && reqEdge) begin
            state <= pte_pkg::PTE_FLUSH;
          end
        end
        pte_pkg::PTE_FLUSH: begin
          if (cfg.outputDir || fifoEmpty) begin
            state <= pte_pkg::PTE_IDLE;
          end
        end
        default: state <= pte_pkg::PTE_IDLE;
      endcase
    end
  end
  logic running;
  assign running = (state == pte_pkg::PTE_RUN) && started && !finalPending;
  // ----------------------------------------------------------------
  // Width and port mapping
  // ----------------------------------------------------------------
  logic [31:0] laneMask;
  logic [31:0] packedIn;
  always_comb begin
    laneMask = 32'h00000000;
    packedIn = 32'h00000000;
    case (cfg.widthSel)
      pte_pkg::WIDTH_8: begin
        laneMask = cfg.groupTwo ? 32'h00FF0000 : 32'h000000FF;
        packedIn = cfg.groupTwo ? {24'h000000, portSyncB[23:16]}
                                : {24'h000000, portSyncB[7:0]};
      end
      pte_pkg::WIDTH_16: begin
        laneMask = cfg.groupTwo ? 32'hFFFF0000 : 32'h0000FFFF;
        packedIn = cfg.groupTwo ? {16'h0000, portSyncB[31:16]}
                                : {16'h0000, portSyncB[15:0]};
      end
      default: begin
        laneMask = cfg.groupTwo ? 32'h00000000 : 32'hFFFFFFFF;
        packedIn = portSyncB;
      end
    endcase
  end
  assign sampleTake = running && reqEdge && (laneMask != 32'h00000000)
                      && (cfg.outputDir ? !fifoEmpty : !fifoFull);
  // ----------------------------------------------------------------
  // Internal FIFO
  // ----------------------------------------------------------------
  logic [AW:0]   wrPtr;
  logic [AW:0]   rdPtr;
  logic [AW:0]   fill;
  logic          pushEn;
  logic          popEn;
  pte_pkg::pte_word_t pushWord;
  pte_pkg::pte_word_t headWord;
  logic          headValid;
  logic [AW:0]   burstWords;
  logic [AW-1:0] headAddr;
  assign fill      = wrPtr - rdPtr;
  assign fifoEmpty = (fill == '0) && !headValid;
  assign fifoFull  = fill[AW] || (headValid
                     && fill == (AW+1)'(pte_pkg::FIFO_DEPTH - 1));
  // Unaccepted head word keeps its slot and its read address
  assign headAddr  = headValid ? rdPtr[AW-1:0] - 1'b1 : rdPtr[AW-1:0];
  assign burstWords = cfg.bigVariant
                    ? (AW+1)'(pte_pkg::BURST_WORDS_BIG)
                    : (AW+1)'(pte_pkg::BURST_WORDS_SML);
  assign fromHostReady = cfg.outputDir && !fifoFull
                         && (state == pte_pkg::PTE_PRELOAD
                          || state == pte_pkg::PTE_RUN);
  assign pushEn   = cfg.outputDir ? (fromHostValid && fromHostReady)
                                  : sampleTake;
  assign pushWord = cfg.outputDir ? fromHost
                  : pte_pkg::pte_word_t'{data: packedIn, last: 1'b0};
  logic [AW:0] sampleCnt;
  assign rawLast = 1'b0;
  pte_fifo_mem #(
    .DW ($bits(pte_pkg::pte_word_t)),
    .AW (AW)
  ) u_mem (
    .clk    (clk),
    .wrEn   (pushEn),
    .wrAddr (wrPtr[AW-1:0]),
    .wrData (pushWord),
    .rdAddr (headAddr),
    .rdData (headWord)
  );
  // Drain towards host: whole bursts in DMA mode until the flush state, single words otherwise
  logic drainOk;
  logic ending;
  assign ending  = (state == pte_pkg::PTE_FLUSH);
  assign drainOk = cfg.irqMode || ending
                 || (fill >= burstWords) || toHostBurst;
  assign popEn   = (fill != '0) && !headValid
                 && (cfg.outputDir ? sampleTake : drainOk);
  always_ff @(posedge clk) begin
    if (!rst_n || (state == pte_pkg::PTE_IDLE && arm)) begin
      wrPtr     <= '0;
      rdPtr     <= '0;
      headValid <= 1'b0;
    end else begin
      if (pushEn) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (popEn) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (popEn && !cfg.outputDir) begin
        headValid <= 1'b1;
      end else if (toHostValid && toHostReady) begin
        headValid <= 1'b0;
      end
    end
  end
  // Burst flag stays up until the burst's words have all gone
  always_ff @(posedge clk) begin
    if (!rst_n || (state == pte_pkg::PTE_IDLE && arm)) begin
      toHostBurst <= 1'b0;
      sampleCnt   <= '0;
    end else if (!cfg.irqMode && !toHostBurst && fill >= burstWords) begin
      // A word popped on this edge already belongs to the burst
      toHostBurst <= !(popEn && burstWords == (AW+1)'(1));
      sampleCnt   <= popEn ? burstWords - 1'b1 : burstWords;
    end else if (toHostBurst && popEn) begin
      sampleCnt   <= sampleCnt - 1'b1;
      toHostBurst <= (sampleCnt != (AW+1)'(1));
    end
  end
  assign toHostValid = headValid;
  assign toHost      = headWord;
  // ----------------------------------------------------------------
  // Output drive and acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      portOut  <= pte_pkg::WORD_RESET;
      portOe_n <= 32'hFFFFFFFF;
      ackOut   <= 1'b0;
    end else begin
      portOe_n <= cfg.outputDir && state != pte_pkg::PTE_IDLE
                  ? ~laneMask : 32'hFFFFFFFF;
      ackOut   <= cfg.handshake && sampleTake;
      if (cfg.outputDir && popEn) begin
        case (cfg.widthSel)
          pte_pkg::WIDTH_8:  portOut <= {4{headWord.data[7:0]}};
          pte_pkg::WIDTH_16: portOut <= {2{headWord.data[15:0]}};
          default:           portOut <= headWord.data;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // Transfer counts and coherent readback
  // ----------------------------------------------------------------
  logic [pte_pkg::COUNT_W-1:0] counts [0:3];
  logic [1:0]                  curIdx;
  logic [1:0]                  rdIdx;
  assign curIdx = {cfg.outputDir, cfg.groupTwo};
  assign rdIdx  = {countSelOut, countSelGrp2};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        counts[i] <= pte_pkg::COUNT_RESET;
      end
    end else if (state == pte_pkg::PTE_IDLE && arm) begin
      counts[curIdx] <= pte_pkg::COUNT_RESET;
    end else if (sampleTake && counts[curIdx] != '1) begin
      counts[curIdx] <= counts[curIdx] + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      countLow  <= 32'h00000000;
      countHigh <= 32'h00000000;
    end else if (readCountLow) begin
      countLow  <= counts[rdIdx][31:0];
      countHigh <= counts[rdIdx][63:32];
    end
  end
  // ----------------------------------------------------------------
  // Status and events
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy          <= 1'b0;
      progressEvent <= 1'b0;
      sampleEvent   <= 1'b0;
    end else begin
      busy          <= (state != pte_pkg::PTE_IDLE);
      progressEvent <= cfg.outputDir && fromHostValid && fromHostReady;
      sampleEvent   <= cfg.irqMode && toHostValid && toHostReady;
    end
  end
endmodule : pte_engine

// file: pte_pkg.sv
// Shared constants and carrier types for the pattern transfer engine.
// Assumes a single 200 MHz clock domain and no register bus.
package pte_pkg;

  // ----------------------------------------------------------------
  // Widths and burst sizes
  // ----------------------------------------------------------------
  localparam int PORT_W          = 8;
  localparam int WORD_W          = 32;
  localparam int COUNT_W         = 64;
  localparam int BURST_BYTES_BIG = 32;
  localparam int BURST_BYTES_SML = 4;
  localparam int BURST_WORDS_BIG = BURST_BYTES_BIG / 4;
  localparam int BURST_WORDS_SML = BURST_BYTES_SML / 4;
  localparam int FIFO_DEPTH      = 16;
  localparam int FIFO_AW         = 4;
  localparam int PRELOAD_W       = 16;

  // ----------------------------------------------------------------
  // Width select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_RESET = 64'h0000000000000000;
  localparam logic [WORD_W-1:0]  WORD_RESET  = 32'h00000000;

  typedef enum logic [1:0] {
    PTE_IDLE,
    PTE_PRELOAD,
    PTE_RUN,
    PTE_FLUSH
  } pte_state_t;

  // Configuration bundle written by software
  typedef struct packed {
    logic       outputDir;    // 1 = generate, 0 = acquire
    logic       handshake;    // 1 = handshaking, 0 = pattern
    logic       irqMode;      // 1 = per-sample handoff, 0 = DMA bursts
    logic       bigVariant;   // 1 = 32-byte bursts, 0 = 4-byte bursts
    logic       groupTwo;     // 1 = timing group 2
    logic [1:0] widthSel;
    logic       reqFalling;   // 1 = sample on falling pacing edge
    logic       useBegin;
    logic       useHalt;
    logic       finite;
    logic       preloadOff;
  } pte_cfg_t;

  // Word moving to or from host memory
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              last;
  } pte_word_t;

endpackage : pte_pkg

// file: pte_fifo_mem.sv
// Small dual-port word memory used as the internal transfer FIFO store.
// Assumes one clock; read data is registered.
`timescale 1ns/1ps
module pte_fifo_mem #(
  parameter int DW = 33,
  parameter int AW = 4
) (
  // Clock
  input  wire logic          clk,
  // Write side
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // Read side
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    rdData <= mem[rdAddr];
  end
endmodule : pte_fifo_mem

// file: pte_engine_properties.sv
// Concurrent checks on the pattern transfer engine ports.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module pte_engine_checker (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Watched ports
  input wire pte_pkg::pte_cfg_t  cfg,
  input wire logic               arm,
  input wire logic               readCountLow,
  input wire logic [31:0]        countLow,
  input wire logic [31:0]        countHigh,
  input wire logic               busy,
  input wire logic               progressEvent,
  input wire logic               sampleEvent,
  input wire pte_pkg::pte_word_t toHost,
  input wire logic               toHostBurst,
  input wire logic               toHostValid,
  input wire logic               toHostReady,
  input wire logic               fromHostValid,
  input wire logic               fromHostReady,
  input wire logic [31:0]        portOe_n,
  input wire logic               ackOut
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_BUSY_ON_ARM: assert property (arm && !busy |=> ##1 busy)
    else $error("busy did not follow arm");
  AST_COUNT_STANDS: assert property (!readCountLow |=>
    $stable(countLow) && $stable(countHigh))
    else $error("count readback moved without a read");
  AST_SAMPLE_IRQ: assert property (sampleEvent |-> cfg.irqMode)
    else $error("sample event outside per-sample mode");
  AST_IRQ_DELIVER: assert property (
    cfg.irqMode && toHostValid && toHostReady |=> sampleEvent)
    else $error("delivered word gave no sample event");
  AST_PROGRESS_CAUSE: assert property (
    progressEvent |-> $past(fromHostValid && fromHostReady))
    else $error("progress event without a host word");
  AST_PROGRESS_EACH: assert property (
    fromHostValid && fromHostReady |=> progressEvent)
    else $error("host word gave no progress event");
  AST_INPUT_NO_DRIVE: assert property (
    busy && !cfg.outputDir |=> &portOe_n)
    else $error("port driven during acquisition");
  AST_OUTPUT_NO_UPLOAD: assert property (
    cfg.outputDir |-> !toHostValid)
    else $error("upload word during generation");
  AST_WORD_HELD: assert property (
    toHostValid && !toHostReady |=> toHostValid && $stable(toHost))
    else $error("upload word dropped before acceptance");
  AST_ACK_HANDSHAKE: assert property (ackOut |-> cfg.handshake)
    else $error("acknowledge outside handshaking");
  AST_BURST_DMA_ONLY: assert property (cfg.irqMode |-> !toHostBurst)
    else $error("burst flag raised in per-sample mode");
endmodule : pte_engine_checker

bind pte_engine pte_engine_checker u_pte_engine_checker (
  .clk(clk), .rst_n(rst_n), .cfg(cfg), .arm(arm),
  .readCountLow(readCountLow), .countLow(countLow),
  .countHigh(countHigh), .busy(busy), .progressEvent(progressEvent),
  .sampleEvent(sampleEvent), .toHost(toHost), .toHostValid(toHostValid),
  .toHostBurst(toHostBurst),
  .toHostReady(toHostReady), .fromHostValid(fromHostValid),
  .fromHostReady(fromHostReady), .portOe_n(portOe_n), .ackOut(ackOut)
);

// file: pte_peripheral.sv
// Peripheral model: pacing strobe, triggers and port data on the pins.
// Assumes the engine samples its pins through synchronisers.
`timescale 1ns/1ps
module pte_peripheral (
  // Clock
  input  wire logic        clk,
  // Pins
  input  wire logic [31:0] portOut,
  input  wire logic        ackOut,
  output logic             reqPin,
  output logic             beginTriggerPin,
  output logic             haltTriggerPin,
  output logic      [31:0] portIn
);
  int acks = 0;

  initial begin
    reqPin = 1'b0;
    beginTriggerPin = 1'b0;
    haltTriggerPin = 1'b0;
    portIn = 32'h00000000;
  end

  always @(posedge clk) if (ackOut === 1'b1) acks++;

  // One strobe pulse, data stable across both edges, then scrambled
  task automatic strobe(input logic [31:0] d, output logic [31:0] seen);
    portIn = d;
    repeat (4) @(negedge clk);
    reqPin = 1'b1;
    repeat (8) @(negedge clk);
    seen = portOut;
    reqPin = 1'b0;
    repeat (8) @(negedge clk);
    portIn = ~d;
  endtask : strobe

  task automatic pulse(input logic isBegin);
    beginTriggerPin = isBegin;
    haltTriggerPin = !isBegin;
    repeat (6) @(negedge clk);
    beginTriggerPin = 1'b0;
    haltTriggerPin = 1'b0;
    repeat (6) @(negedge clk);
  endtask : pulse
endmodule : pte_peripheral

// file: tb_pattern_transfer_engine.sv
// Self-checking bench for the pattern transfer engine.
// Assumes the peripheral model on the pins; host memory is modelled here.
`timescale 1ns/1ps
module tb_pattern_transfer_engine;
  logic                            clk = 1'b0;
  logic                            rst_n = 1'b0;
  pte_pkg::pte_cfg_t               cfg = '0;
  logic                            arm = 1'b0;
  logic                            swStop = 1'b0;
  logic [pte_pkg::PRELOAD_W-1:0]   preloadAmount = '0;
  logic                            readCountLow = 1'b0;
  logic                            countSelOut = 1'b0;
  logic                            countSelGrp2 = 1'b0;
  logic [31:0]                     countLow, countHigh, portIn, portOut;
  logic [31:0]                     portOe_n;
  logic                            busy, progressEvent, sampleEvent;
  logic                            toHostBurst, ackOut, reqPin;
  logic                            beginTriggerPin, haltTriggerPin;
  pte_pkg::pte_word_t              toHost;
  pte_pkg::pte_word_t              fromHost = '0;
  logic                            toHostValid, fromHostReady;
  logic                            toHostReady = 1'b0;
  logic                            fromHostValid = 1'b0;
  logic [31:0]                     q[$];
  logic [31:0]                     hw[8];
  int                              num_errors = 0;
  int                              checks_done = 0;
  int                              seed = 86;
  int                              got = 0;
  int                              hi = 0;
  // Scenario table: config bits and sample count
  logic [11:0] tc[7] = '{12'h100, 12'h0B0, 12'h240, 12'h580, 12'h20C,
                         12'h820, 12'h841};
  int          tn[7] = '{9, 3, 2, 8, 2, 4, 4};

  always #2.5 clk = ~clk;

  pte_engine u_pte_engine (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .arm(arm), .swStop(swStop),
    .preloadAmount(preloadAmount), .readCountLow(readCountLow),
    .countSelOut(countSelOut), .countSelGrp2(countSelGrp2),
    .countLow(countLow), .countHigh(countHigh), .busy(busy),
    .progressEvent(progressEvent), .sampleEvent(sampleEvent),
    .toHost(toHost), .toHostValid(toHostValid), .toHostBurst(toHostBurst),
    .toHostReady(toHostReady), .fromHost(fromHost),
    .fromHostValid(fromHostValid), .fromHostReady(fromHostReady),
    .reqPin(reqPin), .beginTriggerPin(beginTriggerPin),
    .haltTriggerPin(haltTriggerPin), .portIn(portIn), .portOut(portOut),
    .portOe_n(portOe_n), .ackOut(ackOut));

  pte_peripheral u_pte_peripheral (
    .clk(clk), .portOut(portOut), .ackOut(ackOut), .reqPin(reqPin),
    .beginTriggerPin(beginTriggerPin), .haltTriggerPin(haltTriggerPin),
    .portIn(portIn));

  // ----------------------------------------------------------------
  // Host memory side and result watcher
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    toHostReady <= ($random(seed) & 3) != 0;
    fromHostValid <= cfg.outputDir && hi < 8;
    fromHost <= {hw[hi % 8], 1'b0};
  end

  always @(posedge clk) begin
    if (fromHostValid && fromHostReady)
      hi <= hi + 1;
    if (rst_n && toHostValid && toHostReady) begin
      got <= got + 1;
      if (q.size() == 0)
        chk("toHost", 'x, toHost.data);
      else
        chk("toHost", q.pop_front(), toHost.data);
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [31:0] expIn(pte_pkg::pte_cfg_t c,
                                        logic [31:0] d);
    if (c.widthSel == pte_pkg::WIDTH_8)
      return {24'h000000, c.groupTwo ? d[23:16] : d[7:0]};
    if (c.widthSel == pte_pkg::WIDTH_16)
      return {16'h0000, c.groupTwo ? d[31:16] : d[15:0]};
    return d;
  endfunction : expIn

  function automatic logic [31:0] expOut(pte_pkg::pte_cfg_t c,
                                         logic [31:0] w);
    if (c.widthSel == pte_pkg::WIDTH_8)
      return {4{w[7:0]}};
    if (c.widthSel == pte_pkg::WIDTH_16)
      return {2{w[15:0]}};
    return w;
  endfunction : expOut

  task automatic run(input logic [11:0] cv, input int n);
    pte_pkg::pte_cfg_t c;
    logic [31:0] d;
    logic [31:0] s;
    int base;
    int ab;
    c = cv;
    cfg = c;
    countSelOut = c.outputDir;
    countSelGrp2 = c.groupTwo;
    preloadAmount = c.outputDir ? 16'h0002 : 16'h0000;
    hi = 0;
    foreach (hw[i]) hw[i] = $random(seed);
    base = got;
    ab = u_pte_peripheral.acks;
    @(negedge clk) arm = 1'b1;
    @(negedge clk) arm = 1'b0;
    repeat (20) @(negedge clk);
    if (c.useBegin) begin
      u_pte_peripheral.pulse(1'b0);
      u_pte_peripheral.pulse(1'b1);
    end
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      if (!c.outputDir)
        q.push_back(expIn(c, d));
      u_pte_peripheral.strobe(d, s);
      if (c.outputDir)
        chk("portOut", expOut(c, hw[k]), s);
      if (k == 6 && c.bigVariant && !c.irqMode)
        chk("heldWords", 32'h0, got - base);
    end
    repeat (30) @(negedge clk);
    d = (c.bigVariant && !c.irqMode) ? n - n % 8 : n;
    if (!c.outputDir)
      chk("wordsOut", d, got - base);
    if (c.handshake)
      chk("acks", n, u_pte_peripheral.acks - ab);
    if (c.useHalt) begin
      u_pte_peripheral.pulse(1'b0);
    end else begin
      @(negedge clk) swStop = 1'b1;
      @(negedge clk) swStop = 1'b0;
    end
    for (int i = 0; busy !== 1'b0 || q.size() != 0; i++) begin
      if (i == 2000) begin
        num_errors++;
        results();
      end
      @(negedge clk);
    end
    if (!c.outputDir) begin
      @(negedge clk) readCountLow = 1'b1;
      @(negedge clk) readCountLow = 1'b0;
      @(negedge clk);
      chk("countLow", n, countLow);
      chk("countHigh", 32'h0, countHigh);
    end
  endtask : run

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    for (int t = 0; t < 7; t++) begin
      run(tc[t], tn[t]);
      $display("test %0d done", t);
    end
    results();
  end
endmodule : tb_pattern_transfer_engine
